/* core/dccp_consts.vh */
// Offsets, field positions, masks, reset values, clock source codes and fifo sizes of the clock and panel register bank
`ifndef DCCP_CONSTS_VH
`define DCCP_CONSTS_VH
`define DCCP_IDX_PAIRED 8'h26
`define DCCP_IDX_MEMCLK 8'h27
`define DCCP_IDX_PIXCLK 8'h28
`define DCCP_IDX_FIFOTH 8'h29
`define DCCP_IDX_PANARCH 8'h30
`define DCCP_IDX_PANMODE 8'h31
`define DCCP_IDX_PANPOL 8'h32
`define DCCP_RESET_VAL 8'h00
`define DCCP_MASK_PAIRED 8'h0F
`define DCCP_MASK_MEMCLK 8'h0F
`define DCCP_MASK_PIXCLK 8'hFF
`define DCCP_MASK_FIFOTH 8'hFF
`define DCCP_MASK_PANARCH 8'h01
`define DCCP_MASK_PANMODE 8'hDF
`define DCCP_MASK_PANPOL 8'hF7
`define DCCP_BIT_SEL_RD_DIS 0
`define DCCP_BIT_GLB_RD_DIS 1
`define DCCP_BIT_C2_WR_EN 2
`define DCCP_BIT_C1_WR_DIS 3
`define DCCP_BIT_CRT_TEST 0
`define DCCP_BIT_PAN_SRC 1
`define DCCP_BIT_DAC_SRC 2
`define DCCP_BIT_LUT_BYPASS 3
`define DCCP_BIT_PAN_EN 4
`define DCCP_BIT_ICON_DST 6
`define DCCP_BIT_CURS_DST 7
`define DCCP_BIT_MEM_TRI 0
`define DCCP_BIT_SIM_HSP 1
`define DCCP_BIT_SIM_VSP 2
`define DCCP_CLK_PLL_MEM 2'h0
`define DCCP_CLK_PLL_PIX 2'h1
`define DCCP_CLK_MEM 2'h2
`define DCCP_CLK_SYS 2'h3
`define DCCP_WFIFO_SLOTS 16
`define DCCP_FIFO_LVL_W 5
`endif

/* core/dccp_regs.v */
// Indexed clock, panel and paired-access register bank with its steering logic
`timescale 1ns/1ps
`default_nettype none
`include "dccp_consts.vh"
module dccp_regs
(
  input wire clk,
  input wire reset_n,
  // Sequencer index and data ports, one-cycle strobes
  input wire indexWrite,
  input wire [7:0] indexData,
  input wire dataWrite,
  input wire dataRead,
  input wire [7:0] writeData,
  output reg [7:0] readData,
  output reg readValid,
  output reg [7:0] seqIndex,
  // Paired controller register access from the CRT register file
  input wire pairedAccess,
  input wire [7:0] pairedIndex,
  input wire [7:0] c1ReadData,
  input wire [7:0] c2ReadData,
  input wire pairedRead,
  input wire pairedWrite,
  output reg [7:0] pairedReadData,
  output reg c1WriteStrobe,
  output reg c2WriteStrobe,
  // Clock sources
  input wire memPllClock,
  input wire pixelPllClock,
  input wire sysClock,
  input wire crystalInputPin,
  input wire localBusEnablePin,
  input wire externalClockConfigBit,
  input wire extMemclkSelect,
  input wire extPixclkSelect,
  output reg memoryClock,
  output reg firstCtrlPixelClock,
  output reg secondCtrlPixelClock,
  // Fifo levels and requests
  input wire [4:0] panelWriteFifoLevel,
  input wire [4:0] panelReadFifoLevel,
  input wire [4:0] secondCtrlFifoLevel,
  output reg panelWriteDrainReq,
  output reg panelReadUrgentReq,
  output reg secondCtrlUrgentReq,
  // Display routing and panel control
  input wire tvModeBit,
  input wire miscHsyncLow,
  input wire miscVsyncLow,
  input wire [23:0] crtRgbData,
  input wire [23:0] firstCtrlPanelData,
  input wire [23:0] secondCtrlPanelData,
  output reg [23:0] panelDataOut,
  output reg panelScanSingle,
  output reg dacFromSecond,
  output reg panelFromSecond,
  output reg lookupBypassTest,
  output reg panelPowerOnStart,
  output reg panelPowerDownStart,
  output reg panelClockEnable,
  output reg iconToSecond,
  output reg cursorToSecond,
  output reg hsyncActiveLow,
  output reg vsyncActiveLow,
  output reg memPortTristate
);

  ////////////////////////////////////////////////////////////////////////////
  // Threshold code to slot count, used by two fifos
  function [4:0] slotThreshold;
    input [1:0] code;
    begin
      case (code)
        2'h0: slotThreshold = 5'h02;
        2'h1: slotThreshold = 5'h04;
        2'h2: slotThreshold = 5'h08;
        default: slotThreshold = 5'h0C;
      endcase
    end
  endfunction

  // Timing registers that the selective read disable covers
  // Indices 00h-07h, 10h-12h and 15h-16h of the crt register file
  function isTimingIndex;
    input [7:0] idx;
    begin
      isTimingIndex = (idx <= 8'h07) || (idx >= 8'h10 && idx <= 8'h12) ||
        (idx == 8'h15) || (idx == 8'h16);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  reg [7:0] pairedSel_reg;
  reg [7:0] memClkCtl_reg;
  reg [7:0] pixClkCtl_reg;
  reg [7:0] fifoTh_reg;
  reg [7:0] panArch_reg;
  reg [7:0] panMode_reg;
  reg [7:0] panPol_reg;
  reg [7:0] seqIndex_next;
  reg [7:0] readData_next;
  reg panelEnPrev_reg;
  // Controller 1 write disable also locks the sequencer index onto the paired
  // select register, so software can always reach the bit that unlocks it
  wire c1WrDis = pairedSel_reg[`DCCP_BIT_C1_WR_DIS];
  wire [7:0] effIndex = c1WrDis ? `DCCP_IDX_PAIRED : seqIndex;

  // Index port; while writes to controller 1 are disabled the index stays locked
  always @*
  begin
    seqIndex_next = seqIndex;
    if (indexWrite && !c1WrDis)
      seqIndex_next = indexData;
  end

  // Register writes through the data port with reserved bits masked
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      seqIndex <= `DCCP_RESET_VAL;
      pairedSel_reg <= `DCCP_RESET_VAL;
      memClkCtl_reg <= `DCCP_RESET_VAL;
      pixClkCtl_reg <= `DCCP_RESET_VAL;
      fifoTh_reg <= `DCCP_RESET_VAL;
      panArch_reg <= `DCCP_RESET_VAL;
      panMode_reg <= `DCCP_RESET_VAL;
      panPol_reg <= `DCCP_RESET_VAL;
    end
    else
    begin
      seqIndex <= seqIndex_next;
      // Reserved bits are masked off so they store and read back as zero
      if (dataWrite)
      begin
        case (effIndex)
          `DCCP_IDX_PAIRED: pairedSel_reg <= writeData & `DCCP_MASK_PAIRED;
          `DCCP_IDX_MEMCLK: memClkCtl_reg <= writeData & `DCCP_MASK_MEMCLK;
          `DCCP_IDX_PIXCLK: pixClkCtl_reg <= writeData & `DCCP_MASK_PIXCLK;
          `DCCP_IDX_FIFOTH: fifoTh_reg <= writeData & `DCCP_MASK_FIFOTH;
          `DCCP_IDX_PANARCH: panArch_reg <= writeData & `DCCP_MASK_PANARCH;
          `DCCP_IDX_PANMODE: panMode_reg <= writeData & `DCCP_MASK_PANMODE;
          `DCCP_IDX_PANPOL: panPol_reg <= writeData & `DCCP_MASK_PANPOL;
          default: ;
        endcase
      end
    end
  end

  // Read mux; unmapped indices read zero
  // While the index is locked reads also return the paired select register
  always @*
  begin
    case (effIndex)
      `DCCP_IDX_PAIRED: readData_next = pairedSel_reg;
      `DCCP_IDX_MEMCLK: readData_next = memClkCtl_reg;
      `DCCP_IDX_PIXCLK: readData_next = pixClkCtl_reg;
      `DCCP_IDX_FIFOTH: readData_next = fifoTh_reg;
      `DCCP_IDX_PANARCH: readData_next = panArch_reg;
      `DCCP_IDX_PANMODE: readData_next = panMode_reg;
      `DCCP_IDX_PANPOL: readData_next = panPol_reg;
      default: readData_next = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Paired register steering
  // Global read disable wins over the selective one
  wire useSecondRead = pairedSel_reg[`DCCP_BIT_GLB_RD_DIS] ||
    (pairedSel_reg[`DCCP_BIT_SEL_RD_DIS] && isTimingIndex(pairedIndex));

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      readData <= 8'h00;
      readValid <= 1'b0;
      pairedReadData <= 8'h00;
      c1WriteStrobe <= 1'b0;
      c2WriteStrobe <= 1'b0;
    end
    else
    begin
      // Read data is captured only on a read strobe and then stands
      readValid <= dataRead;
      if (dataRead)
        readData <= readData_next;
      // Paired read data holds until the next paired read
      if (pairedAccess && pairedRead)
        pairedReadData <= useSecondRead ? c2ReadData : c1ReadData;
      // Both strobes may fire on one write for mirroring
      c1WriteStrobe <= pairedAccess && pairedWrite && !c1WrDis;
      c2WriteStrobe <= pairedAccess && pairedWrite &&
        pairedSel_reg[`DCCP_BIT_C2_WR_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock selection and division, sampled as synchronous levels
  // External clock pins replace the pll clocks only when configured as inputs
  wire pllPixSrc = (!externalClockConfigBit && extPixclkSelect) ?
    crystalInputPin : pixelPllClock;
  wire pllMemSrc = (!externalClockConfigBit && extMemclkSelect) ?
    localBusEnablePin : memPllClock;
  reg intMemSrc;
  reg pixSrcA;
  reg pixSrcB;

  always @*
  begin
    // Internal memory clock source
    case (memClkCtl_reg[1:0])
      `DCCP_CLK_PLL_PIX: intMemSrc = pllPixSrc;
      `DCCP_CLK_SYS: intMemSrc = sysClock;
      default: intMemSrc = pllMemSrc;
    endcase
    // Pixel sources A and B
    case (pixClkCtl_reg[1:0])
      `DCCP_CLK_MEM: pixSrcA = memoryClock;
      `DCCP_CLK_SYS: pixSrcA = sysClock;
      default: pixSrcA = pllPixSrc;
    endcase
    case (pixClkCtl_reg[5:4])
      `DCCP_CLK_MEM: pixSrcB = memoryClock;
      `DCCP_CLK_SYS: pixSrcB = sysClock;
      default: pixSrcB = pllPixSrc;
    endcase
  end

  // Three dividers: rising edges of the source counted, output held per ratio.
  // Sources are sampled levels, so they must stay below half the system clock;
  // divide by three gives a two-to-one duty cycle rather than an even one.
  wire [2:0] divSrc = {pixSrcB, pixSrcA, intMemSrc};
  wire [5:0] divCode = {pixClkCtl_reg[7:6], pixClkCtl_reg[3:2], memClkCtl_reg[3:2]};
  wire [2:0] divOut;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : gDiv
      reg prev_reg;
      reg [1:0] cnt_reg;
      reg out_reg;
      wire [1:0] ratioCode = divCode[2*g+1 -: 2];
      wire rise = divSrc[g] && !prev_reg;
      // Position after the next source rise, wrapping after ratio code plus one rises
      wire [1:0] cntNext = (cnt_reg >= ratioCode) ? 2'h0 : cnt_reg + 2'h1;
      // High phase in source periods: two when dividing by three or four, one otherwise
      wire [1:0] highLen = ratioCode[1] ? 2'h2 : 2'h1;
      always @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          prev_reg <= 1'b0;
          cnt_reg <= 2'h0;
          out_reg <= 1'b0;
        end
        else
        begin
          prev_reg <= divSrc[g];
          if (ratioCode == 2'h0)
          begin
            // Divide by one follows the source a cycle late
            cnt_reg <= 2'h0;
            out_reg <= divSrc[g];
          end
          else if (rise)
          begin
            // One output period every ratio code plus one source periods
            cnt_reg <= cntNext;
            out_reg <= cntNext < highLen;
          end
        end
      end
      assign divOut[g] = out_reg;
    end
  endgenerate

  // Software must space source and divider updates
  // Outputs come straight from the divider flops
  always @*
  begin
    memoryClock = divOut[0];
    firstCtrlPixelClock = divOut[1];
    secondCtrlPixelClock = divOut[2];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fifo requests and panel control outputs
  // Simultaneous display: panel on and panel and dac fed by the same controller
  wire simulDisplay = panMode_reg[`DCCP_BIT_PAN_EN] &&
    (panMode_reg[`DCCP_BIT_PAN_SRC] == panMode_reg[`DCCP_BIT_DAC_SRC]);

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      panelWriteDrainReq <= 1'b0;
      panelReadUrgentReq <= 1'b0;
      secondCtrlUrgentReq <= 1'b0;
      panelDataOut <= 24'h000000;
      panelScanSingle <= 1'b0;
      dacFromSecond <= 1'b0;
      panelFromSecond <= 1'b0;
      lookupBypassTest <= 1'b0;
      panelEnPrev_reg <= 1'b0;
      panelPowerOnStart <= 1'b0;
      panelPowerDownStart <= 1'b0;
      panelClockEnable <= 1'b0;
      iconToSecond <= 1'b0;
      cursorToSecond <= 1'b0;
      hsyncActiveLow <= 1'b0;
      vsyncActiveLow <= 1'b0;
      memPortTristate <= 1'b0;
    end
    else
    begin
      // Write fifo fills up to its threshold, read fifos drain down to theirs
      panelWriteDrainReq <= panelWriteFifoLevel >= slotThreshold(fifoTh_reg[1:0]);
      panelReadUrgentReq <= panelReadFifoLevel <= {1'b0, fifoTh_reg[5:2]};
      secondCtrlUrgentReq <= secondCtrlFifoLevel <= slotThreshold(fifoTh_reg[7:6]);
      panelScanSingle <= panArch_reg[0];
      // Crt test mode overrides the panel source select
      if (panMode_reg[`DCCP_BIT_CRT_TEST])
        panelDataOut <= crtRgbData;
      else if (panMode_reg[`DCCP_BIT_PAN_SRC])
        panelDataOut <= secondCtrlPanelData;
      else
        panelDataOut <= firstCtrlPanelData;
      panelFromSecond <= panMode_reg[`DCCP_BIT_PAN_SRC] &&
        !panMode_reg[`DCCP_BIT_CRT_TEST];
      dacFromSecond <= panMode_reg[`DCCP_BIT_DAC_SRC] && !tvModeBit;
      lookupBypassTest <= panMode_reg[`DCCP_BIT_LUT_BYPASS];
      // Edges of the panel enable start the power sequences
      panelEnPrev_reg <= panMode_reg[`DCCP_BIT_PAN_EN];
      panelPowerOnStart <= panMode_reg[`DCCP_BIT_PAN_EN] && !panelEnPrev_reg;
      panelPowerDownStart <= !panMode_reg[`DCCP_BIT_PAN_EN] && panelEnPrev_reg;
      panelClockEnable <= panMode_reg[`DCCP_BIT_PAN_EN];
      iconToSecond <= panMode_reg[`DCCP_BIT_ICON_DST];
      cursorToSecond <= panMode_reg[`DCCP_BIT_CURS_DST];
      hsyncActiveLow <= simulDisplay ? panPol_reg[`DCCP_BIT_SIM_HSP] : miscHsyncLow;
      vsyncActiveLow <= simulDisplay ? panPol_reg[`DCCP_BIT_SIM_VSP] : miscVsyncLow;
      memPortTristate <= panPol_reg[`DCCP_BIT_MEM_TRI];
    end
  end

endmodule
`default_nettype wire

/* sim/dccp_regs_properties.sv */
// Concurrent checks on the ports of the clock and panel register bank
`timescale 1ns/1ps
`default_nettype none
module dccp_regs_properties
(
  input wire clk,
  input wire reset_n,
  input wire dataWrite,
  input wire dataRead,
  input wire indexWrite,
  input wire [7:0] writeData,
  input wire [7:0] readData,
  input wire readValid,
  input wire [7:0] seqIndex,
  input wire pairedAccess,
  input wire pairedRead,
  input wire pairedWrite,
  input wire [7:0] c1ReadData,
  input wire [7:0] c2ReadData,
  input wire [7:0] pairedReadData,
  input wire c1WriteStrobe,
  input wire c2WriteStrobe,
  input wire tvModeBit,
  input wire dacFromSecond,
  input wire panelClockEnable,
  input wire panelPowerOnStart,
  input wire panelPowerDownStart
);
  logic [3:0] pairSel_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of the paired select register, locked index sends writes there
  always @(posedge clk or negedge reset_n)
    if (!reset_n)
      pairSel_reg <= 4'h0;
    else if (dataWrite && (pairSel_reg[3] || seqIndex == 8'h26))
      pairSel_reg <= writeData[3:0];
  ////////////////////////////////////////////////////////////////////////////////
  read_answer_a: assert property (dataRead |=> readValid)
    else $error("read gave no valid pulse");
  unmapped_zero_a: assert property (dataRead && !pairSel_reg[3] &&
    (seqIndex < 8'h26 || (seqIndex > 8'h29 && seqIndex < 8'h30) || seqIndex > 8'h32)
    |=> readData == 8'h00) else $error("unmapped read not zero");
  glb_read_a: assert property (pairedAccess && pairedRead && pairSel_reg[1]
    |=> pairedReadData == $past(c2ReadData)) else $error("global read not c2");
  plain_read_a: assert property (pairedAccess && pairedRead && pairSel_reg == 4'h0
    |=> pairedReadData == $past(c1ReadData)) else $error("plain read not c1");
  c2_gate_a: assert property (c2WriteStrobe |->
    $past(pairSel_reg[2]) && $past(pairedWrite)) else $error("c2 write while blocked");
  c1_gate_a: assert property (c1WriteStrobe |->
    !$past(pairSel_reg[3]) && $past(pairedWrite)) else $error("c1 write while blocked");
  mirror_both_a: assert property (pairedAccess && pairedWrite && pairSel_reg[2]
    && !pairSel_reg[3] |=> c1WriteStrobe && c2WriteStrobe) else $error("no mirror");
  index_lock_a: assert property (pairSel_reg[3] && indexWrite |=> $stable(seqIndex))
    else $error("index moved while locked");
  power_on_a: assert property ($rose(panelClockEnable) |-> panelPowerOnStart)
    else $error("no power on pulse");
  power_down_a: assert property ($fell(panelClockEnable) |-> panelPowerDownStart)
    else $error("no power down pulse");
  tv_dac_a: assert property (tvModeBit [*2] |-> !dacFromSecond)
    else $error("tv mode dac not c1");
  // Main scenarios
  cover property (pairedWrite && pairSel_reg == 4'h4);
  cover property (pairSel_reg[3] && indexWrite);
  cover property ($rose(panelClockEnable));
endmodule
bind dccp_regs dccp_regs_properties chk_u (.*);
`default_nettype wire

/* sim/dccp_regs_tb.sv */
// Self-checking bench for the clock and panel register bank
`timescale 1ns/1ps
`default_nettype none
`include "dccp_consts.vh"
module dccp_regs_tb;
  logic clk, reset_n, indexWrite, dataWrite, dataRead, pairedAccess, pairedRead, pairedWrite;
  logic memPllClock, pixelPllClock, sysClock, crystalInputPin, localBusEnablePin;
  logic externalClockConfigBit, extMemclkSelect, extPixclkSelect, tvModeBit;
  logic miscHsyncLow, miscVsyncLow, readValid, c1WriteStrobe, c2WriteStrobe;
  logic [7:0] indexData, writeData, pairedIndex, c1ReadData, c2ReadData;
  logic [7:0] readData, seqIndex, pairedReadData;
  logic [4:0] panelWriteFifoLevel, panelReadFifoLevel, secondCtrlFifoLevel;
  logic [23:0] crtRgbData, firstCtrlPanelData, secondCtrlPanelData, panelDataOut;
  logic memoryClock, firstCtrlPixelClock, secondCtrlPixelClock, panelWriteDrainReq;
  logic panelReadUrgentReq, secondCtrlUrgentReq, panelScanSingle, dacFromSecond;
  logic panelFromSecond, lookupBypassTest, panelPowerOnStart, panelPowerDownStart;
  logic panelClockEnable, iconToSecond, cursorToSecond, hsyncActiveLow, vsyncActiveLow;
  logic memPortTristate;
  int fail_count = 0;
  int cmp_count = 0;
  logic [7:0] idx[7] = '{8'h27, 8'h28, 8'h29, 8'h30, 8'h31, 8'h32, 8'h26};
  logic [7:0] msk[7] = '{`DCCP_MASK_MEMCLK, `DCCP_MASK_PIXCLK, `DCCP_MASK_FIFOTH,
    `DCCP_MASK_PANARCH, `DCCP_MASK_PANMODE, `DCCP_MASK_PANPOL, `DCCP_MASK_PAIRED};
  int thr[4] = '{2, 4, 8, 12};
  wire [2:0] divClk = {secondCtrlPixelClock, firstCtrlPixelClock, memoryClock};
  dccp_regs dut_u (.*);
  ////////////////////////////////////////////////////////////////////////////////
  // Free-running system clock
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Index then data port write, returns when outputs have followed
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge clk) {indexWrite, indexData} <= {1'h1, i};
    @(posedge clk) {indexWrite, dataWrite, writeData} <= {2'h1, d};
    @(posedge clk) dataWrite <= 1'h0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    @(posedge clk) {indexWrite, indexData} <= {1'h1, i};
    @(posedge clk) {indexWrite, dataRead} <= 2'h1;
    @(posedge clk) dataRead <= 1'h0;
    #1;
    chk("readValid", 1'h1, readValid);
    chk("readData", e, readData);
  endtask
  task automatic pr(input logic [7:0] i);
    @(posedge clk) {pairedAccess, pairedRead, pairedWrite, pairedIndex} <= {3'h7, i};
    @(posedge clk) {pairedAccess, pairedRead, pairedWrite} <= 3'h0;
    #1;
  endtask
  // Toggles the system clock input and measures one divided clock's period in cycles
  task automatic per(input string n, input int j, input int e);
    int r;
    int k1;
    int k2;
    logic [2:0] p;
    r = 0;
    k1 = 0;
    k2 = 0;
    p = divClk;
    for (int k = 0; k < 64; k++)
    begin
      @(posedge clk) sysClock <= ~sysClock;
      #1;
      if (divClk[j] && !p[j])
      begin
        r++;
        k1 = k2;
        k2 = k;
      end
      p = divClk;
    end
    chk(n, 24'(e), 24'((r > 2) ? k2 - k1 : 0));
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    #3000000;
    fail_count++;
    print_verdict;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {reset_n, indexWrite, dataWrite, dataRead, pairedAccess, pairedRead, pairedWrite} = 7'h0;
    {memPllClock, pixelPllClock, sysClock, crystalInputPin, localBusEnablePin} = 5'h0;
    {extMemclkSelect, extPixclkSelect, tvModeBit, miscVsyncLow} = 4'h0;
    {externalClockConfigBit, miscHsyncLow} = 2'h3;
    {indexData, writeData, pairedIndex, c1ReadData, c2ReadData} = {24'h0, 16'hA55A};
    {panelWriteFifoLevel, panelReadFifoLevel, secondCtrlFifoLevel} = 15'h0;
    {crtRgbData, firstCtrlPanelData, secondCtrlPanelData} = {24'h111111, 24'h222222, 24'h333333};
    repeat (20) @(posedge clk);
    reset_n <= 1'h1;
    for (int k = 0; k < 7; k++) rd(idx[k], 8'h00);
    rd(8'h2A, 8'h00);
    for (int k = 0; k < 7; k++)
    begin
      wr(idx[k], 8'hFF);
      rd(idx[k], msk[k]);
    end
    chk("memPortTristate", 1'h1, memPortTristate);
    for (int k = 6; k >= 0; k--) wr(idx[k], 8'h00);
    chk("memPortTristate", 1'h0, memPortTristate);
    $display("reset and reserved test done");
    for (int s = 0; s < 16; s++)
    begin
      wr((s > 8) ? 8'h27 : 8'h26, s[7:0]);
      if (s > 8) rd(8'h27, s[7:0]);
      chk("seqIndex", 8'h26, seqIndex);
      pr(8'h00);
      chk("c1WriteStrobe", !s[3], c1WriteStrobe);
      chk("c2WriteStrobe", s[2], c2WriteStrobe);
      chk("pairedReadData", (s[1:0] != 0) ? 8'h5A : 8'hA5, pairedReadData);
      pr(8'h08);
      chk("pairedReadData", s[1] ? 8'h5A : 8'hA5, pairedReadData);
    end
    wr(8'h27, 8'h00);
    $display("paired access test done");
    // Only source fields change, dividers stay at one
    for (int c = 0; c < 4; c++)
    begin
      wr(`DCCP_IDX_MEMCLK, c[7:0]);
      wr(`DCCP_IDX_PIXCLK, {2'h0, c[1:0], 2'h0, c[1:0]});
      for (int v = 0; v < 3; v++)
      begin
        @(posedge clk) {memPllClock, pixelPllClock, sysClock} <= 3'h4 >> v;
        cyc(4);
        chk("memoryClock", v == 0 ? c[0] == 0 : v == 1 ? c == 1 : c == 3, memoryClock);
        chk("firstPix", v == 0 ? c == 2 : v == 1 ? c < 2 : c == 3, firstCtrlPixelClock);
        chk("secondPix", v == 0 ? c == 2 : v == 1 ? c < 2 : c == 3, secondCtrlPixelClock);
      end
    end
    @(posedge clk) {externalClockConfigBit, extMemclkSelect, localBusEnablePin} <= 3'h3;
    wr(`DCCP_IDX_MEMCLK, 8'h00);
    chk("memoryClock", 1'h1, memoryClock);
    @(posedge clk) externalClockConfigBit <= 1'h1;
    // System clock as source of all three, then all three dividers stepped together, second pixel divider in reverse order
    wr(`DCCP_IDX_MEMCLK, 8'h03);
    cyc(10);
    for (int d = 0; d < 4; d++)
    begin
      wr(`DCCP_IDX_MEMCLK, {4'h0, d[1:0], 2'h3});
      wr(`DCCP_IDX_PIXCLK, {2'(3 - d), 2'h3, d[1:0], 2'h3});
      per("memClkPeriod", 0, 2 * d + 2);
      per("pixAPeriod", 1, 2 * d + 2);
      per("pixBPeriod", 2, 8 - 2 * d);
    end
    $display("clock select test done");
    for (int i = 0; i < 4; i++)
    begin
      wr(`DCCP_IDX_FIFOTH, {i[1:0], 4'(3 * i + 1), i[1:0]});
      for (int a = 0; a < 2; a++)
      begin
        @(posedge clk) panelWriteFifoLevel <= 5'(thr[i] - 1 + a);
        panelReadFifoLevel <= 5'(3 * i + 2 - a);
        secondCtrlFifoLevel <= 5'(thr[i] + 1 - a);
        cyc(2);
        chk("panelWriteDrainReq", a, panelWriteDrainReq);
        chk("panelReadUrgentReq", a, panelReadUrgentReq);
        chk("secondCtrlUrgentReq", a, secondCtrlUrgentReq);
      end
    end
    $display("fifo threshold test done");
    wr(`DCCP_IDX_PANMODE, 8'hCE);
    chk("route", 5'h1F, {iconToSecond, cursorToSecond, dacFromSecond, panelFromSecond,
      lookupBypassTest});
    chk("panelDataOut", 24'h333333, panelDataOut);
    @(posedge clk) tvModeBit <= 1'h1;
    cyc(2);
    chk("dacFromSecond", 1'h0, dacFromSecond);
    @(posedge clk) tvModeBit <= 1'h0;
    wr(`DCCP_IDX_PANMODE, 8'h11);
    chk("powerOn", 2'h3, {panelPowerOnStart, panelClockEnable});
    chk("panelDataOut", 24'h111111, panelDataOut);
    wr(`DCCP_IDX_PANPOL, 8'h06);
    chk("syncLow", 2'h3, {hsyncActiveLow, vsyncActiveLow});
    wr(`DCCP_IDX_PANPOL, 8'h00);
    chk("hsyncActiveLow", 1'h0, hsyncActiveLow);
    wr(`DCCP_IDX_PANMODE, 8'h02);
    chk("powerDown", 2'h2, {panelPowerDownStart, panelClockEnable});
    chk("hsyncActiveLow", 1'h1, hsyncActiveLow);
    wr(`DCCP_IDX_PANARCH, 8'h01);
    chk("panelScanSingle", 1'h1, panelScanSingle);
    $display("panel control test done");
    print_verdict;
  end
endmodule
`default_nettype wire
